// file: eeprom_pkg.sv
// Purpose: Shared constants and types for the two-wire EEPROM target
// Assumes: 10 MHz system clock, 2048-byte array, 16-byte pages
// Notes:   Every figure used by more than one file lives here
package eeprom_pkg;

  // ------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned PAGE_W     = 4;
  localparam int unsigned BYTE_W     = 8;

  // ------------------------------------------------------------
  // Target address byte layout
  // ------------------------------------------------------------
  localparam logic [3:0]  TYPE_CODE  = 4'hA;
  localparam int unsigned TYPE_LSB   = 4;
  localparam int unsigned UPPER_MSB  = 3;
  localparam int unsigned UPPER_LSB  = 1;
  localparam int unsigned DIR_BIT    = 0;

  // ------------------------------------------------------------
  // Bit counter marks within one byte slot
  // ------------------------------------------------------------
  localparam logic [3:0]  BIT_ACK     = 4'h8;
  localparam logic [3:0]  BIT_ACK_END = 4'h9;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned TWR_MS     = 10;
  // Longest time, rounded down to whole cycles
  localparam int unsigned TWR_CYCLES = TWR_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // Reset values of synchronised pins {scl, sda, wp, rst_active}
  // ------------------------------------------------------------
  localparam logic [3:0]  PIN_RST    = 4'hC;

  // ------------------------------------------------------------
  // Protocol states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_MEMADDR,
    ST_WDATA,
    ST_READ,
    ST_IGNORE
  } state_t;

endpackage : eeprom_pkg

// file: eeprom_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Synchronous active-high reset
// Notes:   First stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none
module eeprom_sync #(
  parameter int unsigned       WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // ------------------------------------------------------------
  // Two stages
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : eeprom_sync
`default_nettype wire

// file: eeprom_array.sv
// Purpose: Nonvolatile array model with a whole-page write port
// Assumes: Flip-flop storage, combinational read by index
// Notes:   A page commit writes every masked byte in one edge
`timescale 1ns/1ps
`default_nettype none
module eeprom_array #(
  parameter int unsigned ADDR_W = eeprom_pkg::ADDR_W,
  parameter int unsigned PAGE_W = eeprom_pkg::PAGE_W
) (
  // Clock
  input  wire logic                         clock_i,
  // Read port
  input  wire logic [ADDR_W-1:0]            rd_addr_i,
  output logic      [7:0]                   rd_data_o,
  // Page write port
  input  wire logic                         wr_en_i,
  input  wire logic [ADDR_W-PAGE_W-1:0]     wr_page_i,
  input  wire logic [(2**PAGE_W)*8-1:0]     wr_data_i,
  input  wire logic [(2**PAGE_W)-1:0]       wr_mask_i
);

  localparam int unsigned PAGE_BYTES = 2**PAGE_W;

  if (ADDR_W <= PAGE_W)
  begin : g_bad_geometry
    $error("array must hold more than one page");
  end

  logic [7:0] mem [2**ADDR_W];

  // ------------------------------------------------------------
  // One write lane per byte of the page
  // ------------------------------------------------------------
  // One process owns the array, so lanes never count as rival writers
  always_ff @(posedge clock_i)
  begin
    for (int i = 0; i < PAGE_BYTES; i++)
    begin
      if (wr_en_i && wr_mask_i[i])
        mem[{wr_page_i, PAGE_W'(i)}] <= wr_data_i[i*8 +: 8];
    end
  end

  // Contents survive reset, as nonvolatile storage should
  assign rd_data_o = mem[rd_addr_i];

endmodule : eeprom_array
`default_nettype wire

// file: eeprom_i2c_target.sv
// Purpose: Two-wire target front end for a 2048-byte EEPROM array
// Assumes: 10 MHz clock; bus pins sampled, open-drain data line
// Notes:   Page buffer commits on STOP; bus is deaf while busy
//
// How it works
// - Target address must carry the fixed type code in its top nibble
// - Next three address bits are upper array address bits, not select
// - Address byte LSB is direction: one reads, zero writes
// - Acknowledge the address byte only on match, then read or write
// - Receiver pulls data low in the ninth clock to acknowledge
// - Once write-selected, acknowledge memory address and every data byte
// - Read: send eight bits, release, continue on ack else wait STOP
// - STOP after a write starts programming; ignore bus until done
// - Page write accepts up to sixteen bytes for one cycle
// - Each page data byte bumps only low pointer bits
// - Beyond sixteen bytes the low pointer wraps and overwrites
// - STOP commits the whole buffered page in one cycle
// - Polling: withhold ack while programming, ack once finished
// - Write-protect high: ack addresses, nack first data, no programming
// - Address counter holds last accessed address plus one
// - Counter rolls from top address back to zero
// - Current read: ack, send one byte, controller nacks and stops
// - Random read: dummy write, repeated START, read returns that byte
// - START and STOP detected with clock high; idle until START
// - Interface silent during programming, at most ten milliseconds
// - Active reset input blocks accesses and acknowledges
// - Sequential read sends next byte per ack, full address increment
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_target #(
  parameter int unsigned TWR_CYCLES = eeprom_pkg::TWR_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // Two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // Side pins
  input  wire logic wp_i,
  input  wire logic rst_active_i,
  // Status
  output logic      busy_o
);

  // ------------------------------------------------------------
  // Local sizes and checks
  // ------------------------------------------------------------
  localparam int unsigned AW = eeprom_pkg::ADDR_W;
  localparam int unsigned PW = eeprom_pkg::PAGE_W;
  localparam int unsigned NB = 2**PW;
  localparam int unsigned CW = $clog2(TWR_CYCLES + 1);

  if (TWR_CYCLES < 8)
  begin : g_bad_twr
    $error("TWR_CYCLES must be at least 8");
  end

  // Type code test, used by ack choice and state choice
  function automatic logic type_match(input logic [7:0] b);
    type_match = (b[7:eeprom_pkg::TYPE_LSB] == eeprom_pkg::TYPE_CODE);
  endfunction : type_match

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [3:0]              pins_s;
  logic                    scl_s;
  logic                    sda_s;
  logic                    wp_s;
  logic                    rst_s;
  logic                    scl_d_reg;
  logic                    sda_d_reg;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  logic                    byte_done;
  logic                    ack_end;
  logic                    ack_now;
  logic                    load_rd;
  logic                    commit;
  eeprom_pkg::state_t      state_reg;
  logic [3:0]              bit_cnt_reg;
  logic [7:0]              shift_reg;
  logic [7:0]              tx_reg;
  logic                    mack_reg;
  logic                    rw_reg;
  logic [2:0]              upper_reg;
  logic [AW-1:0]           addr_reg;
  logic [7:0]              buf_reg [NB];
  logic [NB-1:0]           mask_reg;
  logic [NB*8-1:0]         buf_flat;
  logic                    sda_oe_reg;
  logic                    busy_reg;
  logic [CW-1:0]           busy_cnt_reg;
  logic [7:0]              mem_rdata;

  // ------------------------------------------------------------
  // Pin synchronisers and bus events
  // ------------------------------------------------------------
  eeprom_sync #(
    .WIDTH   (4),
    .RST_VAL (eeprom_pkg::PIN_RST)
  ) u_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .async_i ({scl_i, sda_i, wp_i, rst_active_i}),
    .sync_o  (pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign wp_s  = pins_s[1];
  assign rst_s = pins_s[0];

  // Previous samples for edge finding; idle bus is high
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Data edges with clock held high are frame marks
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Ack slot opens on the fall after the eighth bit
  assign byte_done = scl_fall && (bit_cnt_reg == eeprom_pkg::BIT_ACK);
  assign ack_end   = scl_fall && (bit_cnt_reg == eeprom_pkg::BIT_ACK_END);

  // ------------------------------------------------------------
  // Acknowledge decision for received bytes
  // ------------------------------------------------------------
  always_comb
  begin
    ack_now = 1'b0;
    unique case (state_reg)
      eeprom_pkg::ST_DEVADDR: ack_now = type_match(shift_reg);
      eeprom_pkg::ST_MEMADDR: ack_now = 1'b1;
      eeprom_pkg::ST_WDATA:   ack_now = ~wp_s;
      default:                ack_now = 1'b0;
    endcase
  end

  // Next byte to send: on address ack with read, or on controller ack
  assign load_rd = ack_end &&
                   (((state_reg == eeprom_pkg::ST_DEVADDR) && rw_reg) ||
                    ((state_reg == eeprom_pkg::ST_READ) && mack_reg));

  // Page goes to the array only if data arrived and writes are allowed
  assign commit = stop_det && (state_reg == eeprom_pkg::ST_WDATA) &&
                  (mask_reg != '0) && !wp_s && !rst_s;

  // ------------------------------------------------------------
  // Bit counter, receive shifter, controller ack capture
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i || start_det || stop_det || rst_s || ack_end)
      bit_cnt_reg <= '0;
    else if (scl_rise && bit_cnt_reg != eeprom_pkg::BIT_ACK_END)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      shift_reg <= 8'h00;
      mack_reg  <= 1'b0;
    end
    else if (scl_rise && bit_cnt_reg < eeprom_pkg::BIT_ACK)
      shift_reg <= {shift_reg[6:0], sda_s};
    else if (scl_rise && bit_cnt_reg == eeprom_pkg::BIT_ACK)
      mack_reg  <= ~sda_s;
  end

  // Direction and upper address bits from the target byte
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rw_reg    <= 1'b0;
      upper_reg <= 3'h0;
    end
    else if (byte_done && state_reg == eeprom_pkg::ST_DEVADDR)
    begin
      rw_reg    <= shift_reg[eeprom_pkg::DIR_BIT];
      upper_reg <= shift_reg[eeprom_pkg::UPPER_MSB:
                             eeprom_pkg::UPPER_LSB];
    end
  end

  // ------------------------------------------------------------
  // Protocol state
  // ------------------------------------------------------------
  // Busy or reset keeps the machine idle, so polling gets no ack
  always_ff @(posedge clock_i)
  begin
    if (srst_i || rst_s)
      state_reg <= eeprom_pkg::ST_IDLE;
    else if (start_det)
      state_reg <= busy_reg ? eeprom_pkg::ST_IDLE
                            : eeprom_pkg::ST_DEVADDR;
    else if (stop_det)
      state_reg <= eeprom_pkg::ST_IDLE;
    // Only receiving states refuse; idle stays idle while busy
    else if (byte_done && !ack_now &&
             state_reg inside {eeprom_pkg::ST_DEVADDR,
                               eeprom_pkg::ST_WDATA})
      state_reg <= eeprom_pkg::ST_IGNORE;
    else if (ack_end)
    begin
      unique case (state_reg)
        eeprom_pkg::ST_DEVADDR:
          state_reg <= rw_reg ? eeprom_pkg::ST_READ
                              : eeprom_pkg::ST_MEMADDR;
        eeprom_pkg::ST_MEMADDR:
          state_reg <= eeprom_pkg::ST_WDATA;
        eeprom_pkg::ST_READ:
          state_reg <= mack_reg ? eeprom_pkg::ST_READ
                                : eeprom_pkg::ST_IGNORE;
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Data line drive
  // ------------------------------------------------------------
  // Driven only after a clock fall; START, STOP and reset release it at once
  always_ff @(posedge clock_i)
  begin
    if (srst_i || rst_s || start_det || stop_det)
      sda_oe_reg <= 1'b0;
    else if (byte_done)
      sda_oe_reg <= (state_reg == eeprom_pkg::ST_READ) ? 1'b0
                                                         : ack_now;
    else if (ack_end)
      sda_oe_reg <= load_rd ? ~mem_rdata[7] : 1'b0;
    else if (scl_fall && state_reg == eeprom_pkg::ST_READ &&
             bit_cnt_reg != 4'h0 && bit_cnt_reg < eeprom_pkg::BIT_ACK)
      sda_oe_reg <= ~tx_reg[3'(4'h7 - bit_cnt_reg)];
  end

  // Open drain: only the enable moves, the level is always low
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ------------------------------------------------------------
  // Address counter
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      addr_reg <= '0;
    else if (byte_done && state_reg == eeprom_pkg::ST_MEMADDR)
      addr_reg <= {upper_reg, shift_reg};
    else if (byte_done && state_reg == eeprom_pkg::ST_WDATA && !wp_s)
      addr_reg[PW-1:0] <= addr_reg[PW-1:0] + 1'b1;
    else if (load_rd)
      addr_reg <= addr_reg + 1'b1;
  end

  // Byte sent next comes from the counter, then the counter moves on
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      tx_reg <= 8'h00;
    else if (load_rd)
      tx_reg <= mem_rdata;
  end

  // ------------------------------------------------------------
  // Page buffer
  // ------------------------------------------------------------
  // A START mid-page drops the page: a repeated START means no write
  always_ff @(posedge clock_i)
  begin
    if (srst_i || start_det || stop_det)
      mask_reg <= '0;
    else if (byte_done && state_reg == eeprom_pkg::ST_WDATA && !wp_s)
    begin
      buf_reg[addr_reg[PW-1:0]]  <= shift_reg;
      mask_reg[addr_reg[PW-1:0]] <= 1'b1;
    end
  end

  for (genvar i = 0; i < NB; i++)
  begin : g_flat
    assign buf_flat[i*8 +: 8] = buf_reg[i];
  end

  eeprom_array #(
    .ADDR_W (AW),
    .PAGE_W (PW)
  ) u_array (
    .clock_i   (clock_i),
    .rd_addr_i (addr_reg),
    .rd_data_o (mem_rdata),
    .wr_en_i   (commit),
    .wr_page_i (addr_reg[AW-1:PW]),
    .wr_data_i (buf_flat),
    .wr_mask_i (mask_reg)
  );

  // ------------------------------------------------------------
  // Programming cycle timer
  // ------------------------------------------------------------
  // Fixed worst-case length; a real cell may finish sooner
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end
    else if (commit)
    begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= CW'(TWR_CYCLES - 1);
    end
    else if (busy_reg)
    begin
      busy_cnt_reg <= busy_cnt_reg - 1'b1;
      busy_reg     <= (busy_cnt_reg != '0);
    end
  end

  assign busy_o = busy_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_start_sel;
    @(posedge clock_i) disable iff (srst_i)
      start_det && !busy_reg && !rst_s |=>
        state_reg == eeprom_pkg::ST_DEVADDR && bit_cnt_reg == 4'h0;
  endproperty
  a_start_sel: assert property (p_start_sel)
    else $error("START did not select address phase");

  property p_dev_ack;
    @(posedge clock_i) disable iff (srst_i)
      byte_done && state_reg == eeprom_pkg::ST_DEVADDR && !rst_s |=>
        sda_oe_reg == (shift_reg[7:4] == 4'hA);
  endproperty
  a_dev_ack: assert property (p_dev_ack)
    else $error("address ack does not follow type match");

  property p_quiet_busy;
    @(posedge clock_i) disable iff (srst_i)
      busy_reg |-> !sda_oe_reg && state_reg == eeprom_pkg::ST_IDLE;
  endproperty
  a_quiet_busy: assert property (p_quiet_busy)
    else $error("bus answered during programming");

  property p_reset_quiet;
    @(posedge clock_i) disable iff (srst_i)
      rst_s |=> !sda_oe_reg && state_reg == eeprom_pkg::ST_IDLE;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("bus answered while reset input active");

  property p_wp_nack;
    @(posedge clock_i) disable iff (srst_i)
      byte_done && state_reg == eeprom_pkg::ST_WDATA && wp_s |=>
        !sda_oe_reg && state_reg == eeprom_pkg::ST_IGNORE && !commit;
  endproperty
  a_wp_nack: assert property (p_wp_nack)
    else $error("protected data byte was acknowledged");

  property p_page_inc;
    @(posedge clock_i) disable iff (srst_i)
      byte_done && state_reg == eeprom_pkg::ST_WDATA && !wp_s |=>
        addr_reg[10:4] == $past(addr_reg[10:4]) &&
        addr_reg[3:0] == 4'($past(addr_reg[3:0]) + 4'h1);
  endproperty
  a_page_inc: assert property (p_page_inc)
    else $error("page pointer moved outside low bits");

  property p_read_inc;
    @(posedge clock_i) disable iff (srst_i)
      load_rd |=> addr_reg == 11'($past(addr_reg) + 11'h001) &&
                  tx_reg == $past(mem_rdata);
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("read did not fetch and advance counter");

  property p_read_release;
    @(posedge clock_i) disable iff (srst_i)
      byte_done && state_reg == eeprom_pkg::ST_READ && !rst_s |=>
        !sda_oe_reg;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data line held in controller ack slot");

  property p_commit_busy;
    @(posedge clock_i) disable iff (srst_i)
      commit |=> busy_reg ##1 busy_reg[*6];
  endproperty
  a_commit_busy: assert property (p_commit_busy)
    else $error("programming cycle too short");

endmodule : eeprom_i2c_target
`default_nettype wire

// file: i2c_ctrl.sv
// Purpose: Two-wire bus controller model facing the EEPROM target
// Assumes: SCL stands high between frames; SDA has a pull-up
// Notes:   Four clocks per SCL phase, lines change at rising edges
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl (
  // Clock
  input  wire logic clock_i,
  // Bus wires
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  // ----------------------------------------
  // Line primitives
  // ----------------------------------------
  // Idle bus: clock high, data left to the pull-up
  initial
  begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // Data falls while clock high; doubles as repeated START
  task automatic start_cond();
    sda_oe_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask : start_cond

  // Data rises while clock high
  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask : stop_cond

  // Data changes only while clock low
  task automatic bit_out(input logic b);
    sda_oe_o <= ~b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_out

  // Sampled late in the high phase, away from the edge that moves the target
  task automatic bit_in(output logic b);
    sda_oe_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(3);
    @(negedge clock_i);
    b = sda_i;
    tick(1);
    scl_o <= 1'b0;
    tick(2);
  endtask : bit_in

  // ----------------------------------------
  // Byte transfers, MSB first
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask : send_byte

  task automatic read_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(~ack);
  endtask : read_byte
endmodule : i2c_ctrl
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the two-wire EEPROM target
// Assumes: Programming time shortened to 64 clocks
// Notes:   Array holds no reset value, so bytes are written first
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Stimulus, wires and score
  // ----------------------------------------
  logic       clock_i      = 1'b0;
  logic       srst_i       = 1'b1;
  logic       wp_i         = 1'b0;
  logic       rst_active_i = 1'b0;
  wire  logic scl_w;
  wire  logic sda_w;
  wire  logic dut_sda;
  wire  logic dut_oe;
  wire  logic ctl_oe;
  wire  logic busy;
  int         n_errors     = 0;
  int         tests_run    = 0;
  logic [7:0] exp_pg [16];

  always #50 clock_i = ~clock_i;

  // Open-drain data line with pull-up
  assign sda_w = ~(ctl_oe | (dut_oe & ~dut_sda));

  eeprom_i2c_target #(
    .TWR_CYCLES (64)
  ) u_eeprom_i2c_target (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .scl_i        (scl_w),
    .sda_i        (sda_w),
    .sda_o        (dut_sda),
    .sda_oe_o     (dut_oe),
    .wp_i         (wp_i),
    .rst_active_i (rst_active_i),
    .busy_o       (busy)
  );

  i2c_ctrl u_i2c_ctrl (
    .clock_i  (clock_i),
    .sda_i    (sda_w),
    .scl_o    (scl_w),
    .sda_oe_o (ctl_oe)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check

  task automatic flag_is(input logic got, input logic exp);
    check({7'h00, got}, {7'h00, exp});
  endtask : flag_is

  task automatic addr_phase(input logic [10:0] a);
    logic ack;
    u_i2c_ctrl.start_cond();
    u_i2c_ctrl.send_byte({4'hA, a[10:8], 1'b0}, ack);
    flag_is(ack, 1'b1);
    u_i2c_ctrl.send_byte(a[7:0], ack);
    flag_is(ack, 1'b1);
  endtask : addr_phase

  // Bounded wait; a stuck busy shows as a mismatch
  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      @(negedge clock_i);
    flag_is(busy, 1'b0);
  endtask : wait_idle

  task automatic poll(input logic exp);
    logic ack;
    u_i2c_ctrl.start_cond();
    u_i2c_ctrl.send_byte(8'hA0, ack);
    flag_is(ack, exp);
    u_i2c_ctrl.stop_cond();
  endtask : poll

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_byte_write();
    logic ack;
    addr_phase(11'h000);
    u_i2c_ctrl.send_byte(8'hC3, ack);
    flag_is(ack, 1'b1);
    u_i2c_ctrl.stop_cond();
    @(negedge clock_i);
    flag_is(busy, 1'b1);
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    $display("test byte_write done");
  endtask : t_byte_write

  // Seventeen bytes from mid-page: the last lands on the first
  task automatic t_page_write();
    logic ack;
    addr_phase(11'h7F8);
    for (int k = 0; k < 17; k++)
    begin
      u_i2c_ctrl.send_byte(8'h30 + 8'(k), ack);
      flag_is(ack, 1'b1);
      exp_pg[(8 + k) % 16] = 8'h30 + 8'(k);
    end
    u_i2c_ctrl.stop_cond();
    @(negedge clock_i);
    flag_is(busy, 1'b1);
    wait_idle();
    $display("test page_write done");
  endtask : t_page_write

  task automatic t_refuse();
    logic ack;
    u_i2c_ctrl.start_cond();
    u_i2c_ctrl.send_byte(8'hB0, ack);
    flag_is(ack, 1'b0);
    u_i2c_ctrl.stop_cond();
    wp_i <= 1'b1;
    addr_phase(11'h7F0);
    u_i2c_ctrl.send_byte(8'h99, ack);
    flag_is(ack, 1'b0);
    u_i2c_ctrl.stop_cond();
    @(negedge clock_i);
    flag_is(busy, 1'b0);
    @(posedge clock_i);
    wp_i         <= 1'b0;
    rst_active_i <= 1'b1;
    u_i2c_ctrl.tick(4);
    poll(1'b0);
    rst_active_i <= 1'b0;
    u_i2c_ctrl.tick(4);
    $display("test refuse done");
  endtask : t_refuse

  // Random read, then current read running over the top address
  task automatic t_reads();
    logic       ack;
    logic [7:0] d;
    addr_phase(11'h7F0);
    u_i2c_ctrl.start_cond();
    u_i2c_ctrl.send_byte(8'hAF, ack);
    flag_is(ack, 1'b1);
    u_i2c_ctrl.read_byte(d, 1'b0);
    check(d, exp_pg[0]);
    u_i2c_ctrl.stop_cond();
    u_i2c_ctrl.start_cond();
    u_i2c_ctrl.send_byte(8'hA1, ack);
    flag_is(ack, 1'b1);
    for (int j = 1; j < 17; j++)
    begin
      u_i2c_ctrl.read_byte(d, j < 16);
      check(d, (j < 16) ? exp_pg[j] : 8'hC3);
    end
    u_i2c_ctrl.stop_cond();
    $display("test reads done");
  endtask : t_reads

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    u_i2c_ctrl.tick(4);
    t_byte_write();
    t_page_write();
    t_refuse();
    t_reads();
    test_done();
  end

  // About ten times the expected run of some four thousand clocks
  initial
  begin
    #4_000_000;
    n_errors++;
    test_done();
  end
endmodule : tb
`default_nettype wire
